// ### verilog/hwdec_top.sv
`timescale 1ns/1ps
`include "hwdec_regs.svh"

module hwdec_top (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // fetched halfword
   input wire logic insn_valid,
   input wire logic [15:0] insn,
   // decode result, one cycle later
   output logic dec_valid,
   output hwdec_pkg::hwdec_class_e dec_class,
   output logic dec_undefined,
   output logic dec_unpredictable,
   output logic dec_hint_unallocated
);
   import hwdec_pkg::*;

   hwdec_state_s st_q;
   hwdec_state_s st_d;

   always_comb begin
      logic [3:0] upper;
      logic [2:0] lower;
      logic [6:0] misc_op;
      upper = insn[15:12];
      lower = insn[11:9];
      misc_op = insn[11:5];
      st_d = '0;
      st_d.valid = insn_valid;
      st_d.cls = HWDEC_OTHER_GROUP;
      if (insn_valid) begin
         if (insn[15:10] == `HWDEC_GRP_SPECIAL) begin
            casez (insn[9:6])
               4'b00??: st_d.cls = HWDEC_ADD_REG;
               4'b0100: begin
                  st_d.cls = HWDEC_UNPREDICTABLE;
                  st_d.unpred = 1'b1;
               end
               4'b0101: st_d.cls = HWDEC_CMP_REG;
               4'b011?: st_d.cls = HWDEC_CMP_REG;
               4'b10??: st_d.cls = HWDEC_COPY_REG;
               4'b110?: st_d.cls = HWDEC_INDIRECT_BRANCH_STATE;
               default: st_d.cls = HWDEC_INDIRECT_CALL_STATE;
            endcase
         end else if (upper == `HWDEC_UPPER_REG) begin
            case (lower)
               3'h0: st_d.cls = HWDEC_WORD_STORE_REG;
               3'h1: st_d.cls = HWDEC_HALF_STORE_REG;
               3'h2: st_d.cls = HWDEC_BYTE_STORE_REG;
               3'h3: st_d.cls = HWDEC_SIGNED_BYTE_LOAD;
               3'h4: st_d.cls = HWDEC_WORD_LOAD_REG;
               3'h5: st_d.cls = HWDEC_HALF_LOAD_REG;
               3'h6: st_d.cls = HWDEC_BYTE_LOAD_REG;
               default: st_d.cls = HWDEC_SIGNED_HALF_LOAD;
            endcase
         end else if (upper == `HWDEC_UPPER_IMM_WORD) begin
            st_d.cls = lower[2] ? HWDEC_WORD_LOAD_IMM : HWDEC_WORD_STORE_IMM;
         end else if (upper == `HWDEC_UPPER_IMM_BYTE) begin
            st_d.cls = lower[2] ? HWDEC_BYTE_LOAD_IMM : HWDEC_BYTE_STORE_IMM;
         end else if (upper == `HWDEC_UPPER_IMM_HALF) begin
            st_d.cls = lower[2] ? HWDEC_HALF_LOAD_IMM : HWDEC_HALF_STORE_IMM;
         end else if (upper == `HWDEC_UPPER_SP) begin
            st_d.cls = lower[2] ? HWDEC_WORD_LOAD_SP : HWDEC_WORD_STORE_SP;
         end else if (upper == `HWDEC_GRP_MISC) begin
            casez (misc_op)
               7'b00000??: st_d.cls = HWDEC_SP_ADD_IMM;
               7'b00001??: st_d.cls = HWDEC_SP_SUB_IMM;
               7'b001000?: st_d.cls = HWDEC_SIGNED_HALF_EXTEND;
               7'b001001?: st_d.cls = HWDEC_SIGNED_BYTE_EXTEND;
               7'b001010?: st_d.cls = HWDEC_UNSIGNED_HALF_EXTEND;
               7'b001011?: st_d.cls = HWDEC_UNSIGNED_BYTE_EXTEND;
               7'b010????: st_d.cls = HWDEC_STACK_STORE_MULTI;
               `HWDEC_STATE_CHANGE: st_d.cls = HWDEC_PROCESSOR_STATE_CHANGE;
               7'b101000?: st_d.cls = HWDEC_WORD_BYTE_SWAP;
               7'b101001?: st_d.cls = HWDEC_HALFWORD_PAIR_BYTE_SWAP;
               7'b101011?: st_d.cls = HWDEC_SIGNED_HALF_BYTE_SWAP;
               7'b110????: st_d.cls = HWDEC_STACK_LOAD_MULTI;
               7'b1110???: st_d.cls = HWDEC_BREAKPOINT_TRAP;
               7'b1111???: begin
                  // hint space
                  if (insn[3:0] != `HWDEC_HINT_LOW_NONE) begin
                     st_d.cls = HWDEC_UNDEFINED;
                     st_d.undef = 1'b1;
                  end else begin
                     case (insn[7:4])
                        4'h0: st_d.cls = HWDEC_NO_OPERATION;
                        4'h1: st_d.cls = HWDEC_YIELD_HINT;
                        4'h2: st_d.cls = HWDEC_WAIT_EVENT_HINT;
                        4'h3: st_d.cls = HWDEC_WAIT_INTERRUPT_HINT;
                        4'h4: st_d.cls = HWDEC_SEND_EVENT_HINT;
                        default: begin
                           st_d.cls = HWDEC_NO_OPERATION;
                           st_d.hint_unalloc = 1'b1;
                        end
                     endcase
                  end
               end
               default: begin
                  st_d.cls = HWDEC_UNDEFINED;
                  st_d.undef = 1'b1;
               end
            endcase
         end else if (upper == `HWDEC_GRP_BRANCH) begin
            if (insn[11:8] == `HWDEC_BRANCH_UNDEF) begin
               st_d.cls = HWDEC_PERMANENT_UNDEFINED;
               st_d.undef = 1'b1;
            end else if (insn[11:8] == `HWDEC_BRANCH_SVC) begin
               st_d.cls = HWDEC_SUPERVISOR_CALL;
            end else begin
               st_d.cls = HWDEC_COND_BRANCH;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dec_valid = st_q.valid;
   assign dec_class = st_q.cls;
   assign dec_undefined = st_q.undef;
   assign dec_unpredictable = st_q.unpred;
   assign dec_hint_unallocated = st_q.hint_unalloc;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   special_unpred_a: assert property (
      insn_valid && insn[15:10] == 6'b010001 && insn[9:6] == 4'b0100
      |=> dec_unpredictable && dec_class == HWDEC_UNPREDICTABLE && !dec_undefined)
      else $error("special 0100 not unpredictable");

   special_cmp_a: assert property (
      insn_valid && insn[15:10] == 6'b010001 && insn[9:7] == 3'b011
      |=> dec_class == HWDEC_CMP_REG && !dec_unpredictable)
      else $error("special 011x not compare");

   indirect_call_a: assert property (
      insn_valid && insn[15:10] == 6'b010001 && insn[9:7] == 3'b111
      |=> dec_class == HWDEC_INDIRECT_CALL_STATE)
      else $error("special 111x not indirect call");

   reg_access_a: assert property (
      insn_valid && insn[15:9] == 7'b0101_011
      |=> dec_class == HWDEC_SIGNED_BYTE_LOAD)
      else $error("register-offset 011 not signed byte load");

   imm_half_a: assert property (
      insn_valid && insn[15:12] == 4'b1000
      |=> dec_class == ($past(insn[11]) ? HWDEC_HALF_LOAD_IMM : HWDEC_HALF_STORE_IMM))
      else $error("halfword immediate direction wrong");

   sp_word_a: assert property (
      insn_valid && insn[15:12] == 4'b1001 && insn[11]
      |=> dec_class == HWDEC_WORD_LOAD_SP)
      else $error("stack-relative load misdecoded");

   misc_undef_a: assert property (
      insn_valid && insn[15:12] == 4'b1011 && insn[11:5] == 7'b0110_010
      |=> dec_undefined && dec_class == HWDEC_UNDEFINED)
      else $error("unallocated miscellaneous not undefined");

   hint_low_a: assert property (
      insn_valid && insn[15:8] == 8'hBF && insn[3:0] != 4'h0
      |=> dec_undefined && !dec_hint_unallocated)
      else $error("hint with low field not undefined");

   hint_wfi_a: assert property (
      insn_valid && insn == 16'hBF30
      |=> dec_class == HWDEC_WAIT_INTERRUPT_HINT && !dec_undefined)
      else $error("wait interrupt hint misdecoded");

   hint_unalloc_a: assert property (
      insn_valid && insn[15:8] == 8'hBF && insn[3:0] == 4'h0 && insn[7:4] > 4'h4
      |=> dec_class == HWDEC_NO_OPERATION && dec_hint_unallocated && !dec_undefined)
      else $error("unallocated hint not no-op");

   branch_group_a: assert property (
      insn_valid && insn[15:12] == 4'b1101
      |=> (dec_class == HWDEC_COND_BRANCH) == ($past(insn[11:9]) != 3'b111)
          && dec_undefined == ($past(insn[11:8]) == 4'b1110))
      else $error("branch group misdecoded");

   idle_a: assert property (
      !insn_valid |=> !dec_valid && dec_class == HWDEC_OTHER_GROUP && !dec_undefined)
      else $error("idle cycle produced a result");

   result_valid_a: assert property (
      insn_valid |=> dec_valid)
      else $error("accepted halfword gave no result");

   special_add_a: assert property (
      insn_valid && insn[15:10] == 6'b010001 && insn[9:8] == 2'b00
      |=> dec_class == HWDEC_ADD_REG && !dec_unpredictable)
      else $error("special 00xx not register add");

   special_compare_a: assert property (
      insn_valid && insn[15:10] == 6'b010001 && insn[9:6] == 4'b0101
      |=> dec_class == HWDEC_CMP_REG && !dec_unpredictable)
      else $error("special 0101 not compare");

   special_copy_a: assert property (
      insn_valid && insn[15:10] == 6'b010001 && insn[9:8] == 2'b10
      |=> dec_class == HWDEC_COPY_REG)
      else $error("special 10xx not register copy");

   indirect_branch_a: assert property (
      insn_valid && insn[15:10] == 6'b010001 && insn[9:7] == 3'b110
      |=> dec_class == HWDEC_INDIRECT_BRANCH_STATE)
      else $error("special 110x not indirect branch");

   group_other_a: assert property (
      insn_valid && (insn[15:14] == 2'b00 || insn[15:12] == 4'hA || insn[15:12] == 4'hC
      || insn[15:13] == 3'b111) |=> dec_valid && dec_class == HWDEC_OTHER_GROUP && !dec_undefined)
      else $error("halfword outside groups was decoded");

   reg_store_a: assert property (
      insn_valid && insn[15:9] == 7'b0101_000
      |=> dec_class == HWDEC_WORD_STORE_REG)
      else $error("register-offset 000 not word store");

   reg_half_a: assert property (
      insn_valid && insn[15:9] == 7'b0101_101
      |=> dec_class == HWDEC_HALF_LOAD_REG)
      else $error("register-offset 101 not half load");

   reg_signed_half_a: assert property (
      insn_valid && insn[15:9] == 7'b0101_111
      |=> dec_class == HWDEC_SIGNED_HALF_LOAD)
      else $error("register-offset 111 not signed half load");

   imm_word_a: assert property (
      insn_valid && insn[15:12] == 4'b0110
      |=> dec_class == ($past(insn[11]) ? HWDEC_WORD_LOAD_IMM : HWDEC_WORD_STORE_IMM))
      else $error("word immediate direction wrong");

   imm_byte_a: assert property (
      insn_valid && insn[15:12] == 4'b0111
      |=> dec_class == ($past(insn[11]) ? HWDEC_BYTE_LOAD_IMM : HWDEC_BYTE_STORE_IMM))
      else $error("byte immediate direction wrong");

   sp_store_a: assert property (
      insn_valid && insn[15:12] == 4'b1001 && !insn[11]
      |=> dec_class == HWDEC_WORD_STORE_SP)
      else $error("stack-relative store misdecoded");

   sp_adjust_a: assert property (
      insn_valid && insn[15:8] == 8'hB0
      |=> dec_class == ($past(insn[7]) ? HWDEC_SP_SUB_IMM : HWDEC_SP_ADD_IMM))
      else $error("stack adjust misdecoded");

   signed_extend_a: assert property (
      insn_valid && insn[15:7] == 9'b1011_0010_0
      |=> dec_class == ($past(insn[6]) ? HWDEC_SIGNED_BYTE_EXTEND : HWDEC_SIGNED_HALF_EXTEND))
      else $error("signed extend misdecoded");

   unsigned_extend_a: assert property (
      insn_valid && insn[15:7] == 9'b1011_0010_1
      |=> dec_class == ($past(insn[6]) ? HWDEC_UNSIGNED_BYTE_EXTEND : HWDEC_UNSIGNED_HALF_EXTEND))
      else $error("unsigned extend misdecoded");

   word_swap_a: assert property (
      insn_valid && insn[15:6] == 10'b1011_1010_00
      |=> dec_class == HWDEC_WORD_BYTE_SWAP)
      else $error("word byte swap misdecoded");

   pair_swap_a: assert property (
      insn_valid && insn[15:6] == 10'b1011_1010_01
      |=> dec_class == HWDEC_HALFWORD_PAIR_BYTE_SWAP)
      else $error("halfword pair swap misdecoded");

   signed_swap_a: assert property (
      insn_valid && insn[15:6] == 10'b1011_1010_11
      |=> dec_class == HWDEC_SIGNED_HALF_BYTE_SWAP)
      else $error("signed half swap misdecoded");

   stack_store_a: assert property (
      insn_valid && insn[15:9] == 7'b1011_010
      |=> dec_class == HWDEC_STACK_STORE_MULTI && !dec_undefined)
      else $error("stack store misdecoded");

   state_change_a: assert property (
      insn_valid && insn[15:5] == 11'b1011_0110_011
      |=> dec_class == HWDEC_PROCESSOR_STATE_CHANGE && !dec_undefined)
      else $error("state change misdecoded");

   stack_load_a: assert property (
      insn_valid && insn[15:9] == 7'b1011_110
      |=> dec_class == HWDEC_STACK_LOAD_MULTI && !dec_undefined)
      else $error("stack load misdecoded");

   breakpoint_trap_a: assert property (
      insn_valid && insn[15:8] == 8'hBE
      |=> dec_class == HWDEC_BREAKPOINT_TRAP && !dec_undefined)
      else $error("breakpoint misdecoded");

   swap_gap_a: assert property (
      insn_valid && insn[15:6] == 10'b1011_1010_10
      |=> dec_undefined && dec_class == HWDEC_UNDEFINED)
      else $error("unallocated swap not undefined");

   hint_nop_a: assert property (
      insn_valid && insn == 16'hBF00
      |=> dec_class == HWDEC_NO_OPERATION && !dec_hint_unallocated && !dec_undefined)
      else $error("no-op hint misdecoded");

   hint_yield_a: assert property (
      insn_valid && insn == 16'hBF10
      |=> dec_class == HWDEC_YIELD_HINT && !dec_undefined)
      else $error("yield hint misdecoded");

   hint_event_a: assert property (
      insn_valid && insn == 16'hBF20
      |=> dec_class == HWDEC_WAIT_EVENT_HINT && !dec_undefined)
      else $error("wait event hint misdecoded");

   hint_send_a: assert property (
      insn_valid && insn == 16'hBF40
      |=> dec_class == HWDEC_SEND_EVENT_HINT && !dec_undefined)
      else $error("send event hint misdecoded");

   svc_call_a: assert property (
      insn_valid && insn[15:8] == 8'hDF
      |=> dec_class == HWDEC_SUPERVISOR_CALL && !dec_undefined)
      else $error("supervisor call misdecoded");

endmodule : hwdec_top

// ### verilog/hwdec_regs.svh
// Behaviour
// - Special-data field 00xx decodes as register add, 0100 as unpredictable, 0101 as register compare, 10xx as register copy.
// - Special-data field 110x is an indirect branch with state change, 111x the same with a saved return link.
// - The single-item load/store group is selected by upper field 0101, 011x or 100x, and the lower field picks the operation.
// - With upper field 0101 the lower field maps to word, half and byte stores, signed byte load, word, half and byte loads, signed half load.
// - Upper fields 0110, 0111 and 1000 are word, byte and half immediate accesses, stores for lower 0xx and loads for lower 1xx.
// - Upper field 1001 is a stack-relative word store for lower 0xx and a stack-relative word load for lower 1xx.
// - Miscellaneous opcode 00000xx adds an immediate to the stack pointer and 00001xx subtracts one.
// - Miscellaneous opcodes 001000x to 001011x are signed half, signed byte, unsigned half and unsigned byte extends.
// - Miscellaneous opcodes 101000x, 101001x and 101011x are word, halfword-pair and signed-half byte swaps.
// - Miscellaneous 010xxxx is a stack store, 0110011 a state change, 110xxxx a stack load, 1110xxx a breakpoint, 1111xxx the hint space.
// - Every other miscellaneous opcode is flagged undefined.
// - A hint with non-zero low field is undefined whatever the upper field holds.
// - A hint with zero low field maps upper 0000 to 0100 onto no-op, yield, wait event, wait interrupt and send event.
// - Any other hint with zero low field executes as a no-op.
// - Branch-group opcode outside 111x is a conditional branch, 1110 is permanently undefined and 1111 a supervisor call.
`ifndef HWDEC_REGS_SVH
`define HWDEC_REGS_SVH

// top four bits of a halfword select the group, top six for the special-data group
`define HWDEC_GRP_SPECIAL 6'h11
`define HWDEC_UPPER_REG 4'h5
`define HWDEC_UPPER_IMM_WORD 4'h6
`define HWDEC_UPPER_IMM_BYTE 4'h7
`define HWDEC_UPPER_IMM_HALF 4'h8
`define HWDEC_UPPER_SP 4'h9
`define HWDEC_GRP_MISC 4'hB
`define HWDEC_GRP_BRANCH 4'hD
`define HWDEC_BRANCH_UNDEF 4'hE
`define HWDEC_BRANCH_SVC 4'hF
`define HWDEC_STATE_CHANGE 7'h33
`define HWDEC_HINT_LOW_NONE 4'h0

`endif

// ### verilog/hwdec_pkg.sv
package hwdec_pkg;

   typedef enum logic [5:0] {
      HWDEC_OTHER_GROUP = 6'b000000,
      HWDEC_ADD_REG = 6'b000001,
      HWDEC_CMP_REG = 6'b000010,
      HWDEC_COPY_REG = 6'b000011,
      HWDEC_INDIRECT_BRANCH_STATE = 6'b000100,
      HWDEC_INDIRECT_CALL_STATE = 6'b000101,
      HWDEC_WORD_STORE_REG = 6'b000110,
      HWDEC_HALF_STORE_REG = 6'b000111,
      HWDEC_BYTE_STORE_REG = 6'b001000,
      HWDEC_SIGNED_BYTE_LOAD = 6'b001001,
      HWDEC_WORD_LOAD_REG = 6'b001010,
      HWDEC_HALF_LOAD_REG = 6'b001011,
      HWDEC_BYTE_LOAD_REG = 6'b001100,
      HWDEC_SIGNED_HALF_LOAD = 6'b001101,
      HWDEC_WORD_STORE_IMM = 6'b001110,
      HWDEC_WORD_LOAD_IMM = 6'b001111,
      HWDEC_BYTE_STORE_IMM = 6'b010000,
      HWDEC_BYTE_LOAD_IMM = 6'b010001,
      HWDEC_HALF_STORE_IMM = 6'b010010,
      HWDEC_HALF_LOAD_IMM = 6'b010011,
      HWDEC_WORD_STORE_SP = 6'b010100,
      HWDEC_WORD_LOAD_SP = 6'b010101,
      HWDEC_SP_ADD_IMM = 6'b010110,
      HWDEC_SP_SUB_IMM = 6'b010111,
      HWDEC_SIGNED_HALF_EXTEND = 6'b011000,
      HWDEC_SIGNED_BYTE_EXTEND = 6'b011001,
      HWDEC_UNSIGNED_HALF_EXTEND = 6'b011010,
      HWDEC_UNSIGNED_BYTE_EXTEND = 6'b011011,
      HWDEC_WORD_BYTE_SWAP = 6'b011100,
      HWDEC_HALFWORD_PAIR_BYTE_SWAP = 6'b011101,
      HWDEC_SIGNED_HALF_BYTE_SWAP = 6'b011110,
      HWDEC_STACK_STORE_MULTI = 6'b011111,
      HWDEC_PROCESSOR_STATE_CHANGE = 6'b100000,
      HWDEC_STACK_LOAD_MULTI = 6'b100001,
      HWDEC_BREAKPOINT_TRAP = 6'b100010,
      HWDEC_NO_OPERATION = 6'b100011,
      HWDEC_YIELD_HINT = 6'b100100,
      HWDEC_WAIT_EVENT_HINT = 6'b100101,
      HWDEC_WAIT_INTERRUPT_HINT = 6'b100110,
      HWDEC_SEND_EVENT_HINT = 6'b100111,
      HWDEC_COND_BRANCH = 6'b101000,
      HWDEC_PERMANENT_UNDEFINED = 6'b101001,
      HWDEC_SUPERVISOR_CALL = 6'b101010,
      HWDEC_UNDEFINED = 6'b101011,
      HWDEC_UNPREDICTABLE = 6'b101100
   } hwdec_class_e;

   typedef struct packed {
      logic valid;
      hwdec_class_e cls;
      logic undef;
      logic unpred;
      logic hint_unalloc;
   } hwdec_state_s;

endpackage : hwdec_pkg

// ### bench/hwdec_fetch_model.sv
`timescale 1ns/1ps
module hwdec_fetch_model (
   // clock
   input wire logic clk,
   // next halfword chosen by the bench
   input wire logic next_valid,
   input wire logic [15:0] next_insn,
   // towards the decoder
   output logic insn_valid,
   output logic [15:0] insn
);
   initial begin
      insn_valid = 1'h0;
      insn = 16'h0000;
   end
   // presented on the falling edge, stable across the rising edge
   always @(negedge clk) begin
      insn_valid <= next_valid;
      // idle bus toggles so a stale halfword is never mistaken for data
      insn <= next_valid ? next_insn : ~insn;
   end
endmodule : hwdec_fetch_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import hwdec_pkg::*;
   typedef struct packed {
      logic [15:0] hw;
      hwdec_class_e cls;
      logic [2:0] flg;
   } hwdec_row_s;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic next_valid = 1'h0;
   logic [15:0] next_insn = 16'h0000;
   logic insn_valid;
   logic [15:0] insn;
   logic dec_valid;
   hwdec_class_e dec_class;
   logic dec_undefined;
   logic dec_unpredictable;
   logic dec_hint_unallocated;
   wire logic [9:0] seen = {dec_valid, dec_class, dec_undefined, dec_unpredictable,
      dec_hint_unallocated};
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   // flags are undefined, unpredictable, unallocated hint
   hwdec_row_s rows [] = '{
      '{16'h4400, HWDEC_ADD_REG, 3'h0}, '{16'h44C0, HWDEC_ADD_REG, 3'h0},
      '{16'h4500, HWDEC_UNPREDICTABLE, 3'h2}, '{16'h4540, HWDEC_CMP_REG, 3'h0},
      '{16'h4580, HWDEC_CMP_REG, 3'h0}, '{16'h4600, HWDEC_COPY_REG, 3'h0},
      '{16'h4700, HWDEC_INDIRECT_BRANCH_STATE, 3'h0},
      '{16'h4780, HWDEC_INDIRECT_CALL_STATE, 3'h0},
      '{16'h47C0, HWDEC_INDIRECT_CALL_STATE, 3'h0},
      '{16'h5000, HWDEC_WORD_STORE_REG, 3'h0}, '{16'h5200, HWDEC_HALF_STORE_REG, 3'h0},
      '{16'h5400, HWDEC_BYTE_STORE_REG, 3'h0}, '{16'h5600, HWDEC_SIGNED_BYTE_LOAD, 3'h0},
      '{16'h5800, HWDEC_WORD_LOAD_REG, 3'h0}, '{16'h5A00, HWDEC_HALF_LOAD_REG, 3'h0},
      '{16'h5C00, HWDEC_BYTE_LOAD_REG, 3'h0}, '{16'h5E00, HWDEC_SIGNED_HALF_LOAD, 3'h0},
      '{16'h6000, HWDEC_WORD_STORE_IMM, 3'h0}, '{16'h6FFF, HWDEC_WORD_LOAD_IMM, 3'h0},
      '{16'h7000, HWDEC_BYTE_STORE_IMM, 3'h0}, '{16'h7800, HWDEC_BYTE_LOAD_IMM, 3'h0},
      '{16'h8000, HWDEC_HALF_STORE_IMM, 3'h0}, '{16'h8FFF, HWDEC_HALF_LOAD_IMM, 3'h0},
      '{16'h97FF, HWDEC_WORD_STORE_SP, 3'h0}, '{16'h9800, HWDEC_WORD_LOAD_SP, 3'h0},
      '{16'hB000, HWDEC_SP_ADD_IMM, 3'h0}, '{16'hB07F, HWDEC_SP_ADD_IMM, 3'h0},
      '{16'hB080, HWDEC_SP_SUB_IMM, 3'h0}, '{16'hB0FF, HWDEC_SP_SUB_IMM, 3'h0},
      '{16'hB200, HWDEC_SIGNED_HALF_EXTEND, 3'h0},
      '{16'hB240, HWDEC_SIGNED_BYTE_EXTEND, 3'h0},
      '{16'hB280, HWDEC_UNSIGNED_HALF_EXTEND, 3'h0},
      '{16'hB2FF, HWDEC_UNSIGNED_BYTE_EXTEND, 3'h0},
      '{16'hBA00, HWDEC_WORD_BYTE_SWAP, 3'h0},
      '{16'hBA40, HWDEC_HALFWORD_PAIR_BYTE_SWAP, 3'h0},
      '{16'hBAC0, HWDEC_SIGNED_HALF_BYTE_SWAP, 3'h0},
      '{16'hB400, HWDEC_STACK_STORE_MULTI, 3'h0}, '{16'hB5FF, HWDEC_STACK_STORE_MULTI, 3'h0},
      '{16'hB660, HWDEC_PROCESSOR_STATE_CHANGE, 3'h0},
      '{16'hBC00, HWDEC_STACK_LOAD_MULTI, 3'h0}, '{16'hBE00, HWDEC_BREAKPOINT_TRAP, 3'h0},
      '{16'hB100, HWDEC_UNDEFINED, 3'h4}, '{16'hB640, HWDEC_UNDEFINED, 3'h4},
      '{16'hB800, HWDEC_UNDEFINED, 3'h4}, '{16'hBA80, HWDEC_UNDEFINED, 3'h4},
      '{16'hBF01, HWDEC_UNDEFINED, 3'h4}, '{16'hBFF8, HWDEC_UNDEFINED, 3'h4},
      '{16'hBF00, HWDEC_NO_OPERATION, 3'h0}, '{16'hBF10, HWDEC_YIELD_HINT, 3'h0},
      '{16'hBF20, HWDEC_WAIT_EVENT_HINT, 3'h0}, '{16'hBF30, HWDEC_WAIT_INTERRUPT_HINT, 3'h0},
      '{16'hBF40, HWDEC_SEND_EVENT_HINT, 3'h0}, '{16'hBF50, HWDEC_NO_OPERATION, 3'h1},
      '{16'hBFF0, HWDEC_NO_OPERATION, 3'h1}, '{16'hD000, HWDEC_COND_BRANCH, 3'h0},
      '{16'hDDFF, HWDEC_COND_BRANCH, 3'h0}, '{16'hDE00, HWDEC_PERMANENT_UNDEFINED, 3'h4},
      '{16'hDF00, HWDEC_SUPERVISOR_CALL, 3'h0}, '{16'h4000, HWDEC_OTHER_GROUP, 3'h0},
      '{16'hA000, HWDEC_OTHER_GROUP, 3'h0}, '{16'hE000, HWDEC_OTHER_GROUP, 3'h0}
   };

   hwdec_fetch_model fetch (
      .clk(clk),
      .next_valid(next_valid),
      .next_insn(next_insn),
      .insn_valid(insn_valid),
      .insn(insn)
   );

   hwdec_top uut (
      .clk(clk),
      .resetn(resetn),
      .insn_valid(insn_valid),
      .insn(insn),
      .dec_valid(dec_valid),
      .dec_class(dec_class),
      .dec_undefined(dec_undefined),
      .dec_unpredictable(dec_unpredictable),
      .dec_hint_unallocated(dec_hint_unallocated)
   );

   always #5 clk = ~clk;

   task automatic complete_run();
      $display("compares %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [9:0] s, input logic [9:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   // one halfword per cycle, result read after the next rising edge
   task automatic step(input logic v, input logic [15:0] hw);
      next_valid = v;
      next_insn = hw;
      @(negedge clk);
      @(posedge clk);
      #1;
   endtask : step

   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         error_cnt++;
         complete_run();
      end
   end

   initial begin
      repeat (6) @(posedge clk);
      #1;
      chk(seen, {1'h0, HWDEC_OTHER_GROUP, 3'h0});
      @(negedge clk);
      resetn = 1'h1;
      foreach (rows[i]) begin
         step(1'h1, rows[i].hw);
         chk(seen, {1'h1, rows[i].cls, rows[i].flg});
      end
      // reset in mid-stream, then decode on the first edge after release
      step(1'h1, 16'hBF30);
      @(negedge clk);
      resetn = 1'h0;
      #1;
      chk(seen, {1'h0, HWDEC_OTHER_GROUP, 3'h0});
      @(negedge clk);
      resetn = 1'h1;
      @(posedge clk);
      #1;
      chk(seen, {1'h1, HWDEC_WAIT_INTERRUPT_HINT, 3'h0});
      step(1'h0, 16'h0000);
      chk(seen, {1'h0, HWDEC_OTHER_GROUP, 3'h0});
      step(1'h1, 16'hDEFF);
      chk(seen, {1'h1, HWDEC_PERMANENT_UNDEFINED, 3'h4});
      complete_run();
   end
endmodule : tb_top
